// [rtl/gcm_pkg.sv]
// Constants shared by the general configuration and mask register block
package gcm_pkg;
  // Serial command code of the configuration byte
  localparam logic [7:0] CMD_GENERAL_MASK = 8'h17;
  // Command codes of the priority registers the shutdown logic follows
  localparam logic [7:0] CMD_PRIO_1BIT = 8'h15;
  localparam logic [7:0] CMD_PRIO_3BIT_LO = 8'h27;
  localparam logic [7:0] CMD_PRIO_3BIT_HI = 8'h28;
  // Value after reset: interrupt pin enabled, all else clear
  localparam logic [7:0] GMASK_RESET = 8'h80;
  // Field positions inside the configuration byte
  localparam int IRQ_EN_BIT = 7;
  localparam int ACC_WIDTH_BIT = 5;
  localparam int MULTI_PRIO_BIT = 4;
  localparam int CLASS_CHG_BIT = 3;
  localparam int DETECT_CHG_BIT = 2;
  // Channel count and result width per channel
  localparam int NUM_CH = 8;
  localparam int RES_W = 4;
  localparam int PRIO_W = 3;
  // Fast shutdown idle time before priority mode change
  localparam int OSS_IDLE_US = 200;
  localparam int MCLK_MHZ = 50;
  localparam int OSS_IDLE_CYC = OSS_IDLE_US * MCLK_MHZ;
  localparam int OSS_CNT_W = 16;
endpackage

// [rtl/hist_if.sv]
// Carrier between the top and the result history store
interface hist_if;
  import gcm_pkg::*;
  logic [NUM_CH-1:0] done; // One-cycle end-of-cycle strobe per channel
  logic [NUM_CH*RES_W-1:0] result; // Result per channel, valid with done
  logic change_only; // Report only changed results
  logic [NUM_CH-1:0] set_flag; // Registered event-set pulses
  modport src (output done, output result, output change_only, input set_flag);
  modport store (input done, input result, input change_only, output set_flag);
endinterface

// [rtl/result_history.sv]
// Per-channel previous-result store and event-set pulse generator
module result_history
  import gcm_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic rst_n, // Synchronised reset, active low
  hist_if.store h // Strobes, results and event pulses
);
  logic [RES_W-1:0] prev_ff [NUM_CH]; // Last result seen per channel
  logic [RES_W-1:0] nxt_prev [NUM_CH];
  logic [NUM_CH-1:0] seen_ff; // A result was stored since reset
  logic [NUM_CH-1:0] nxt_seen;
  logic [NUM_CH-1:0] flag_ff; // Event-set pulses
  logic [NUM_CH-1:0] nxt_flag;

  // Decide whether a finished cycle raises its event
  function automatic logic event_hit(input logic chg_only, input logic seen,
                                     input logic [RES_W-1:0] prev,
                                     input logic [RES_W-1:0] res);
    // The first result after reset always counts as a change
    event_hit = !chg_only || !seen || (prev != res);
  endfunction

  // Next values for history and pulses
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      nxt_prev[i] = prev_ff[i];
      nxt_seen[i] = seen_ff[i];
      nxt_flag[i] = 1'b0;
      if (h.done[i])
      begin
        nxt_flag[i] = event_hit(h.change_only, seen_ff[i], prev_ff[i],
                                h.result[i*RES_W +: RES_W]);
        nxt_prev[i] = h.result[i*RES_W +: RES_W];
        nxt_seen[i] = 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        prev_ff[i] <= '0;
      end
      seen_ff <= '0;
      flag_ff <= '0;
    end
    else
    begin
      prev_ff <= nxt_prev;
      seen_ff <= nxt_seen;
      flag_ff <= nxt_flag;
    end
  end

  assign h.set_flag = flag_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // Same result again in change-only mode stays silent
  AST_HIST_SAME_SILENT:
    assert property (h.change_only && h.done[0] && seen_ff[0]
                     && (h.result[RES_W-1:0] == prev_ff[0]) |=> !flag_ff[0])
    else $error("Unchanged result raised an event in change-only mode");

  // Different result in change-only mode raises the event
  AST_HIST_DIFF_FLAG:
    assert property (h.change_only && h.done[1] && seen_ff[1]
                     && (h.result[2*RES_W-1:RES_W] != prev_ff[1]) |=> flag_ff[1])
    else $error("Changed result did not raise an event");
endmodule

// [rtl/general_mask_config.sv]
// General configuration and mask register with the logic it steers
// Behaviour
// - Command 17h reads and writes one byte
// - Enable clear keeps interrupt pin inactive
// - Enable set lets unmasked flags drive pin
// - Enable bit never touches event flags
// - Width bit set: 16-bit, one address
// - Width bit clear: two 8-bit addresses
// - Priority bit set: 3-bit from 27h/28h
// - Priority bit clear: 1-bit from 15h
// - Class change-only: flag on differing result
// - Class otherwise: flag every classification cycle
// - Detect change-only: flag on differing result
// - Detect otherwise: flag every detection cycle
module general_mask_config
  import gcm_pkg::*;
#(
  parameter int OSS_IDLE_CYCLES = OSS_IDLE_CYC // Idle cycles before priority change
)
(
  input wire logic mclk, // System clock, 50 MHz
  input wire logic reset_n, // Asynchronous reset, active low
  input wire logic cmd_valid, // Serial command strobe, one cycle
  input wire logic cmd_write, // 1 write, 0 read
  input wire logic [7:0] cmd_code, // Command code
  input wire logic [7:0] cmd_wdata, // Write data byte
  output logic [7:0] cmd_rdata, // Read data byte
  output logic cmd_rvalid, // Read data valid, one cycle
  output logic [7:0] config_byte, // Stored configuration byte
  input wire logic [7:0] int_flags, // Interrupt register bits
  input wire logic [7:0] int_mask, // Interrupt mask, 1 = unmasked
  output logic irq_n, // Interrupt pin, active low
  input wire logic addr_select_lsb, // Address select strap
  input wire logic [6:0] slave_base_addr, // Programmed serial base address
  input wire logic addr_probe, // Received address strobe
  input wire logic [6:0] addr_probe_value, // Received serial address
  output logic addr_hit, // Address answered
  output logic addr_group_high, // Hit belongs to channels 5-8
  output logic access_width_select, // 1 = 16-bit access
  output logic multi_level_priority_select, // 1 = 3-bit priority
  input wire logic [7:0] prio_1bit_bits, // Priority bits of register 15h
  input wire logic [23:0] prio_3bit_levels, // Levels of registers 27h/28h
  output logic [23:0] shutdown_priority, // Applied level per channel
  input wire logic [7:0] class_done, // Classification cycle finished
  input wire logic [31:0] class_result, // Class result per channel
  input wire logic [7:0] detect_done, // Detection cycle finished
  input wire logic [31:0] detect_result, // Detection result per channel
  output logic [7:0] class_event_flag, // Class event set pulses
  output logic [7:0] detect_event_flag, // Detect event set pulses
  input wire logic fast_shutdown_input, // Shutdown bit-stream pin
  output logic fast_shutdown_idle_ok // Pin idle long enough
);
  logic rst_s1_ff; // Reset release stage one
  logic rst_n_sync; // Reset release stage two, used everywhere
  logic [7:0] cfg_ff; // The configuration byte
  logic [7:0] nxt_cfg;
  logic [7:0] rdata_ff; // Read data register
  logic [7:0] nxt_rdata;
  logic rvalid_ff; // Read answer pulse
  logic nxt_rvalid;
  logic irq_n_ff; // Interrupt pin register
  logic nxt_irq_n;
  logic hit_ff; // Address match register
  logic nxt_hit;
  logic group_ff; // Upper channel group register
  logic nxt_group;
  logic [23:0] prio_ff; // Applied priority levels
  logic [23:0] nxt_prio;
  logic oss_s1_ff; // Shutdown pin sync stage one
  logic oss_s2_ff; // Shutdown pin sync stage two
  logic [OSS_CNT_W-1:0] idle_cnt_ff; // Low time of the shutdown pin
  logic [OSS_CNT_W-1:0] nxt_idle_cnt;
  logic idle_ok_ff; // Idle time reached
  logic nxt_idle_ok;
  logic strap_ff; // Address strap caught after reset release
  logic nxt_strap;
  logic cmd_hit; // Command addresses this register

  localparam logic [OSS_CNT_W-1:0] IDLE_LIMIT = OSS_CNT_W'(OSS_IDLE_CYCLES);

  // Reset release: asserts at once, leaves after two edges
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_s1_ff <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_s1_ff <= 1'b1;
      rst_n_sync <= rst_s1_ff;
    end
  end

  // Shutdown pin comes from outside the clock domain
  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      oss_s1_ff <= 1'b0;
      oss_s2_ff <= 1'b0;
    end
    else
    begin
      oss_s1_ff <= fast_shutdown_input;
      oss_s2_ff <= oss_s1_ff;
    end
  end

  assign cmd_hit = cmd_valid && (cmd_code == CMD_GENERAL_MASK);

  // Register access and the read answer
  always_comb
  begin
    nxt_cfg = cfg_ff;
    nxt_rdata = rdata_ff;
    nxt_rvalid = 1'b0;
    if (cmd_hit && cmd_write)
    begin
      nxt_cfg = cmd_wdata;
    end
    else if (cmd_hit)
    begin
      // Reads return the whole byte, spare bits included
      nxt_rdata = cfg_ff;
      nxt_rvalid = 1'b1;
    end
  end

  // Interrupt pin gating; the event path does not see this bit
  always_comb
  begin
    nxt_irq_n = !(cfg_ff[IRQ_EN_BIT] && |(int_flags & int_mask));
  end

  // Serial address answer; strap caught by a clocked process
  always_comb
  begin
    nxt_strap = addr_select_lsb;
    nxt_hit = 1'b0;
    nxt_group = 1'b0;
    if (addr_probe)
    begin
      if (cfg_ff[ACC_WIDTH_BIT])
      begin
        nxt_hit = (addr_probe_value == {slave_base_addr[6:1], 1'b0});
        nxt_group = 1'b0;
      end
      else
      begin
        nxt_hit = (addr_probe_value[6:1] == slave_base_addr[6:1]);
        nxt_group = addr_probe_value[0];
      end
    end
  end

  // Applied shutdown priority per channel
  always_comb
  begin
    nxt_prio = '0;
    if (cfg_ff[MULTI_PRIO_BIT])
    begin
      nxt_prio = prio_3bit_levels;
    end
    else
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        nxt_prio[i*PRIO_W +: PRIO_W] = {2'b00, prio_1bit_bits[i]};
      end
    end
  end

  // Idle-time watch of the shutdown pin; advisory only, the host must keep it
  always_comb
  begin
    nxt_idle_cnt = idle_cnt_ff;
    if (oss_s2_ff)
    begin
      nxt_idle_cnt = '0;
    end
    else if (idle_cnt_ff != IDLE_LIMIT)
    begin
      nxt_idle_cnt = idle_cnt_ff + 1'b1;
    end
    nxt_idle_ok = (nxt_idle_cnt == IDLE_LIMIT);
  end

  // All other block registers, apart from the reset and shutdown pin synchronisers and the event history stores
  always_ff @(posedge mclk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      cfg_ff <= GMASK_RESET;
      rdata_ff <= 8'h00;
      rvalid_ff <= 1'b0;
      irq_n_ff <= 1'b1;
      hit_ff <= 1'b0;
      group_ff <= 1'b0;
      prio_ff <= '0;
      idle_cnt_ff <= '0;
      idle_ok_ff <= 1'b0;
      strap_ff <= 1'b0;
    end
    else
    begin
      cfg_ff <= nxt_cfg;
      rdata_ff <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
      irq_n_ff <= nxt_irq_n;
      hit_ff <= nxt_hit;
      group_ff <= nxt_group;
      prio_ff <= nxt_prio;
      idle_cnt_ff <= nxt_idle_cnt;
      idle_ok_ff <= nxt_idle_ok;
      strap_ff <= nxt_strap;
    end
  end

  // Event history for classification and detection
  hist_if cls_if ();
  hist_if det_if ();

  assign cls_if.done = class_done;
  assign cls_if.result = class_result;
  assign cls_if.change_only = cfg_ff[CLASS_CHG_BIT];
  assign det_if.done = detect_done;
  assign det_if.result = detect_result;
  assign det_if.change_only = cfg_ff[DETECT_CHG_BIT];

  result_history u_cls_hist (
    .mclk (mclk),
    .rst_n (rst_n_sync),
    .h (cls_if.store)
  );

  result_history u_det_hist (
    .mclk (mclk),
    .rst_n (rst_n_sync),
    .h (det_if.store)
  );

  // Outputs, each straight from a register
  assign cmd_rdata = rdata_ff;
  assign cmd_rvalid = rvalid_ff;
  assign config_byte = cfg_ff;
  assign irq_n = irq_n_ff;
  assign addr_hit = hit_ff;
  assign addr_group_high = group_ff;
  assign access_width_select = cfg_ff[ACC_WIDTH_BIT];
  assign multi_level_priority_select = cfg_ff[MULTI_PRIO_BIT];
  assign shutdown_priority = prio_ff;
  assign class_event_flag = cls_if.set_flag;
  assign detect_event_flag = det_if.set_flag;
  assign fast_shutdown_idle_ok = idle_ok_ff;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n_sync);

  // A write then a read of the byte
  sequence s_write_cfg;
    cmd_valid && cmd_write && (cmd_code == CMD_GENERAL_MASK);
  endsequence
  sequence s_read_cfg;
    cmd_valid && !cmd_write && (cmd_code == CMD_GENERAL_MASK);
  endsequence

  AST_READ_BACK:
    assert property (s_write_cfg ##1 s_read_cfg |=>
                     cmd_rvalid && (cmd_rdata == $past(cmd_wdata, 2)))
    else $error("Read did not return the byte written");

  AST_OTHER_CMD_IGNORED:
    assert property (cmd_valid && (cmd_code != CMD_GENERAL_MASK) |=>
                     !cmd_rvalid && $stable(cfg_ff))
    else $error("Foreign command touched the register");

  AST_IRQ_BLOCKED:
    assert property (!cfg_ff[IRQ_EN_BIT] |=> irq_n)
    else $error("Interrupt pin active while disabled");

  AST_IRQ_PASSES:
    assert property (cfg_ff[IRQ_EN_BIT] && |(int_flags & int_mask) |=> !irq_n)
    else $error("Unmasked flag did not drive the pin");

  AST_EVENT_NEEDS_DONE:
    assert property ((detect_done == 8'h00) && (class_done == 8'h00) |=>
                     (detect_event_flag == 8'h00) && (class_event_flag == 8'h00))
    else $error("Event raised without a finished cycle");

  AST_WIDE_ADDR:
    assert property (cfg_ff[ACC_WIDTH_BIT] && addr_probe && addr_probe_value[0] |=>
                     !addr_hit)
    else $error("Odd address answered in 16-bit mode");

  AST_NARROW_ADDR:
    assert property (!cfg_ff[ACC_WIDTH_BIT] && addr_probe
                     && (addr_probe_value == {slave_base_addr[6:1], 1'b1}) |=>
                     addr_hit && addr_group_high)
    else $error("Second address not answered in 8-bit mode");

  AST_PRIO_3BIT:
    assert property (cfg_ff[MULTI_PRIO_BIT] |=> shutdown_priority == $past(prio_3bit_levels))
    else $error("Three-bit levels not applied");

  AST_PRIO_1BIT:
    assert property (!cfg_ff[MULTI_PRIO_BIT] |=>
                     shutdown_priority[2:0] == {2'b00, $past(prio_1bit_bits[0])})
    else $error("One-bit priority not applied");

  AST_CLASS_EVERY:
    assert property (!cfg_ff[CLASS_CHG_BIT] && class_done[2] |=> class_event_flag[2])
    else $error("Classification cycle gave no event");

  AST_DETECT_EVERY:
    assert property (!cfg_ff[DETECT_CHG_BIT] && detect_done[3] |=> detect_event_flag[3])
    else $error("Detection cycle gave no event");

  AST_IDLE_RESTART:
    assert property (oss_s2_ff |=> !fast_shutdown_idle_ok ##1 !fast_shutdown_idle_ok)
    else $error("Idle flag survived shutdown activity");

  AST_RESET_VALUE:
    assert property ($past(!rst_n_sync) |-> cfg_ff == GMASK_RESET)
    else $error("Register not at reset value after reset");
endmodule

// [tb/gcm_host.sv]
// Host model: drives the command port and the fast shutdown pin
module gcm_host
  import gcm_pkg::*;
(
  input wire logic mclk, // System clock
  output logic cmd_valid, // Command strobe
  output logic cmd_write, // 1 write, 0 read
  output logic [7:0] cmd_code, // Command code
  output logic [7:0] cmd_wdata, // Write byte
  input wire logic [7:0] cmd_rdata, // Read byte
  input wire logic cmd_rvalid, // Read answer pulse
  output logic fast_shutdown_input // Shutdown bit-stream pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 8'h00;
    fast_shutdown_input = 1'b0;
  end
  // one byte per command
  // Code and data lines go to the inverse once released, so stale data never looks valid
  task automatic send(input logic wr, input logic [7:0] code, input logic [7:0] data);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_code = code;
    cmd_wdata = data;
    @(posedge mclk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask
  // Answer is registered at the taking edge, so it is read just after it
  task automatic read(input logic [7:0] code, output logic [7:0] data, output logic ok);
    send(1'b0, code, 8'h00);
    ok = cmd_rvalid;
    data = cmd_rdata;
  endtask
  // write then read on consecutive edges, strobe held high between them
  task automatic write_read(input logic [7:0] code, input logic [7:0] data,
                            output logic [7:0] rdata, output logic ok);
    @(posedge mclk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(posedge mclk);
    #1;
    // Only the direction and data change; the strobe stays up
    cmd_write = 1'b0;
    cmd_wdata = ~data;
    @(posedge mclk);
    #1;
    ok = cmd_rvalid;
    rdata = cmd_rdata;
    cmd_valid = 1'b0;
    cmd_code = ~code;
  endtask
  task automatic shutdown_gap(input int high_cyc, input int low_cyc);
    fast_shutdown_input = 1'b1;
    repeat (high_cyc) @(posedge mclk);
    #1;
    fast_shutdown_input = 1'b0;
    repeat (low_cyc) @(posedge mclk);
    #1;
  endtask
endmodule

// [tb/general_mask_config_register_test.sv]
// Self-checking bench for the general configuration and mask register
module general_mask_config_register_test
  import gcm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, reset_n, cmd_valid, cmd_write, cmd_rvalid, irq_n, addr_select_lsb;
  logic addr_probe, addr_hit, addr_group_high, access_width_select;
  logic multi_level_priority_select, fast_shutdown_input, fast_shutdown_idle_ok;
  logic [7:0] cmd_code, cmd_wdata, cmd_rdata, config_byte, int_flags, int_mask;
  logic [6:0] slave_base_addr, addr_probe_value;
  logic [7:0] prio_1bit_bits, class_done, detect_done, class_event_flag, detect_event_flag;
  logic [23:0] prio_3bit_levels, shutdown_priority;
  logic [31:0] class_result, detect_result;
  int failures = 0; // Mismatches seen
  int cmp_count = 0; // Comparisons made
  int cycles = 0; // Run length guard
  // 50 MHz clock
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;
  // Short idle count keeps the shutdown check quick
  general_mask_config #(.OSS_IDLE_CYCLES(8)) u_general_mask_config (.mclk(mclk),
    .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata), .cmd_rvalid(cmd_rvalid),
    .config_byte(config_byte), .int_flags(int_flags), .int_mask(int_mask), .irq_n(irq_n),
    .addr_select_lsb(addr_select_lsb), .slave_base_addr(slave_base_addr),
    .addr_probe(addr_probe), .addr_probe_value(addr_probe_value), .addr_hit(addr_hit),
    .addr_group_high(addr_group_high), .access_width_select(access_width_select),
    .multi_level_priority_select(multi_level_priority_select),
    .prio_1bit_bits(prio_1bit_bits), .prio_3bit_levels(prio_3bit_levels),
    .shutdown_priority(shutdown_priority), .class_done(class_done),
    .class_result(class_result), .detect_done(detect_done), .detect_result(detect_result),
    .class_event_flag(class_event_flag), .detect_event_flag(detect_event_flag),
    .fast_shutdown_input(fast_shutdown_input), .fast_shutdown_idle_ok(fast_shutdown_idle_ok));
  gcm_host u_gcm_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
    .cmd_rvalid(cmd_rvalid), .fast_shutdown_input(fast_shutdown_input));
  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Case-equality compare, so unknowns never match
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] v);
    u_gcm_host.send(1'b1, CMD_GENERAL_MASK, v);
  endtask
  task automatic rd_chk(input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    u_gcm_host.read(CMD_GENERAL_MASK, d, ok);
    chk(24'(ok), 24'h1, "read answer");
    chk(24'(d), 24'(exp), "read byte");
    chk(24'(config_byte), 24'(exp), "config byte");
  endtask
  // Reset value, spare bits, foreign code, read after write
  task automatic t_regs();
    logic [7:0] d;
    logic ok;
    rd_chk(GMASK_RESET);
    wr(8'h43);
    rd_chk(8'h43);
    u_gcm_host.send(1'b1, 8'h16, 8'hFF);
    rd_chk(8'h43);
    u_gcm_host.write_read(CMD_GENERAL_MASK, 8'h5A, d, ok);
    chk(24'(ok), 24'h1, "back-to-back answer");
    chk(24'(d), 24'h5A, "back-to-back byte");
    wr(8'hFF);
    rd_chk(8'hFF);
  endtask
  // Pin follows unmasked flags only while enabled
  task automatic t_irq();
    wr(8'h80);
    int_flags = 8'h10;
    int_mask = 8'h10;
    wait_cyc(2);
    chk(24'(irq_n), 24'h0, "irq unmasked");
    int_mask = 8'hEF;
    wait_cyc(2);
    chk(24'(irq_n), 24'h1, "irq masked");
    int_mask = 8'hFF;
    wr(8'h00);
    wait_cyc(2);
    chk(24'(irq_n), 24'h1, "irq gated");
    int_flags = 8'h00;
  endtask
  task automatic probe(input logic [6:0] v, input logic hit, input logic grp);
    addr_probe = 1'b1;
    addr_probe_value = v;
    wait_cyc(1);
    chk(24'(addr_hit), 24'(hit), "address hit");
    chk(24'(addr_group_high), 24'(grp), "address group");
    // Release and let an edge pass so the next probe never lands in this time step
    addr_probe = 1'b0;
    addr_probe_value = ~v;
    wait_cyc(1);
    chk(24'(addr_hit), 24'h0, "hit pulse end");
  endtask
  // Two addresses in 8-bit mode, one in 16-bit mode
  task automatic t_addr();
    wr(8'h00);
    probe(7'h2B, 1'b1, 1'b1);
    probe(7'h2A, 1'b1, 1'b0);
    wr(8'h20);
    probe(7'h2B, 1'b0, 1'b0);
    probe(7'h2A, 1'b1, 1'b0);
    chk(24'(access_width_select), 24'h1, "width select");
  endtask
  // Priority source follows the priority bit
  task automatic t_prio();
    logic [23:0] e;
    prio_1bit_bits = 8'hA5;
    prio_3bit_levels = 24'hFAC688;
    wr(8'h00);
    wait_cyc(2);
    for (int i = 0; i < 8; i++)
      e[3*i +: 3] = {2'b00, prio_1bit_bits[i]};
    chk(shutdown_priority, e, "1-bit levels");
    u_gcm_host.shutdown_gap(4, 0);
    chk(24'(fast_shutdown_idle_ok), 24'h0, "pin busy");
    u_gcm_host.shutdown_gap(0, 12);
    chk(24'(fast_shutdown_idle_ok), 24'h1, "pin idle");
    wr(8'h10);
    wait_cyc(2);
    chk(shutdown_priority, 24'hFAC688, "3-bit levels");
    chk(24'(multi_level_priority_select), 24'h1, "priority select");
  endtask
  // One end-of-cycle strobe and its event pulse
  task automatic ev(input logic det, input int ch, input logic [3:0] res, input logic exp);
    logic got;
    if (det)
    begin
      detect_done[ch] = 1'b1;
      detect_result[4*ch +: 4] = res;
    end
    else
    begin
      class_done[ch] = 1'b1;
      class_result[4*ch +: 4] = res;
    end
    wait_cyc(1);
    got = det ? detect_event_flag[ch] : class_event_flag[ch];
    detect_done = 8'h00;
    class_done = 8'h00;
    detect_result = ~detect_result;
    class_result = ~class_result;
    chk(24'(got), 24'(exp), det ? "detect event" : "class event");
    // The pulse lasts one cycle; the pause also keeps strobes apart
    wait_cyc(1);
    got = det ? detect_event_flag[ch] : class_event_flag[ch];
    chk(24'(got), 24'h0, "event pulse end");
  endtask
  // Change-only versus every-cycle reporting
  task automatic t_event();
    wr(8'h88);
    ev(1'b0, 0, 4'h5, 1'b1);
    ev(1'b0, 0, 4'h5, 1'b0);
    wr(8'h08);
    ev(1'b0, 0, 4'h6, 1'b1);
    ev(1'b0, 0, 4'h6, 1'b0);
    wr(8'h00);
    ev(1'b0, 0, 4'h6, 1'b1);
    ev(1'b0, 2, 4'h6, 1'b1);
    ev(1'b0, 2, 4'h6, 1'b1);
    wr(8'h04);
    ev(1'b1, 1, 4'h3, 1'b1);
    ev(1'b1, 1, 4'h3, 1'b0);
    ev(1'b1, 1, 4'h9, 1'b1);
    wr(8'h80);
    ev(1'b1, 1, 4'h9, 1'b1);
    ev(1'b1, 3, 4'h9, 1'b1);
    ev(1'b1, 3, 4'h9, 1'b1);
  endtask
  // Hang guard, far above the hundred and ten or so cycles the run needs
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      $display("mismatch at %0t: run did not finish", $time);
      summarize();
    end
  end
  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    int_flags = 8'h00;
    int_mask = 8'h00;
    addr_select_lsb = 1'b0;
    slave_base_addr = 7'h2A;
    addr_probe = 1'b0;
    addr_probe_value = 7'h00;
    prio_1bit_bits = 8'h00;
    prio_3bit_levels = 24'h000000;
    class_done = 8'h00;
    detect_done = 8'h00;
    class_result = 32'h00000000;
    detect_result = 32'h00000000;
    repeat (3) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    wait_cyc(3);
    t_regs();
    t_irq();
    t_addr();
    t_prio();
    t_event();
    summarize();
  end
endmodule
